/* pomc_mode_cfg.sv */
// per-port and global operating mode configuration with an avalon-mm register slave
`include "pomc_cfg.svh"

module pomc_mode_cfg
  import pomc_pkg::*;
#(
  parameter int NPORT = 2
) (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic [`POMC_ADDR_W-1:0]      avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic [NPORT-1:0]             copper_link_in,
  input  wire logic [NPORT-1:0]             serdes_sig_det_in,
  output logic      [NPORT-1:0][1:0]        serdes_media_o,
  output logic      [NPORT-1:0]             serdes_media_en_o,
  output logic      [NPORT-1:0]             media_aneg_en_o,
  output logic      [NPORT-1:0][1:0]        ams_active_o,
  output logic      [NPORT-1:0]             port_sw_reset_o,
  output logic      [NPORT-1:0]             host_proto_1000x_o,
  output logic      [NPORT-1:0]             rate_10_100_allow_o,
  output logic      [NPORT-1:0]             host_aneg_cl37_o,
  output logic      [NPORT-1:0]             host_aneg_sgmii_o,
  output logic      [1:0]                   host_mode_o,
  output logic      [`POMC_SLOTS-1:0]       host_lane_en_o,
  output logic      [`POMC_SLOTS-1:0]       qsgmii_slot_data_o
);

  // the global register region sits right above the port regions
  initial begin
    if (NPORT < 1 || NPORT > 2) begin
      $error("pomc_mode_cfg: NPORT must be 1 or 2");
    end
  end

  // ---------------- bus slave ----------------
  pomc_bus_st_t bus_st_r;
  pomc_bus_st_t bus_st_nxt;
  logic [31:0]  rdata_r;
  logic [31:0]  rdata_nxt;

  wire       bus_req    = avs_read | avs_write;
  wire       bus_accept = bus_req & (bus_st_r == BUS_ACK);
  wire       wr_acc     = bus_accept & avs_write;
  wire       rd_acc     = bus_accept & avs_read;
  wire [1:0] rgn        = avs_address[`POMC_RGN_HI:`POMC_RGN_LO];
  wire [5:0] idx        = avs_address[`POMC_IDX_HI:`POMC_IDX_LO];
  wire       rgn_glb    = (rgn == `POMC_RGN_GLOBAL);
  wire       rgn_port   = (32'(rgn) < NPORT);
  wire [1:0] be16       = avs_byteenable[1:0];

  // one wait state: read data are registered while waitrequest is high
  assign avs_waitrequest = bus_req & (bus_st_r == BUS_IDLE);
  assign bus_st_nxt      = (bus_st_r == BUS_IDLE && bus_req) ? BUS_ACK : BUS_IDLE;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
  endfunction : merge16

  // ---------------- global registers ----------------
  logic [15:0] serdes_cfg_r;
  logic [15:0] host_mode_r;

  wire wr_glb_serdes = wr_acc & rgn_glb & (idx == `POMC_IDX_SERDES);
  wire wr_glb_hmode  = wr_acc & rgn_glb & (idx == `POMC_IDX_HOSTMODE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serdes_cfg_r <= `POMC_SERDES_RST;
      host_mode_r  <= `POMC_HOSTMODE_RST;
    end else begin
      if (wr_glb_serdes) serdes_cfg_r <= merge16(serdes_cfg_r, avs_writedata, be16);
      if (wr_glb_hmode)  host_mode_r  <= merge16(host_mode_r, avs_writedata, be16);
    end
  end

  wire pomc_host_mode_t hmode      = pomc_host_mode_t'(host_mode_r[`POMC_HM_HI:`POMC_HM_LO]);
  wire                  hm_qsgmii  = (hmode == HM_QSGMII);
  wire [3:0]            port_mask  = serdes_cfg_r[`POMC_MASK_HI:`POMC_MASK_LO];

  // ---------------- per-port registers ----------------
  logic [NPORT-1:0][15:0] ctrl_r;
  logic [NPORT-1:0][15:0] adv_r;
  logic [NPORT-1:0]       bcast_r;
  logic [NPORT-1:0][15:0] mode_wr_r;
  logic [NPORT-1:0][15:0] mode_act_r;
  logic [NPORT-1:0]       hostan_r;
  logic [NPORT-1:0][1:0]  evt_r;
  logic [NPORT-1:0]       swrst_r;
  logic [NPORT-1:0][1:0]  cu_sync_r;
  logic [NPORT-1:0][1:0]  sd_sync_r;
  logic [NPORT-1:0][15:0] port_rd;
  pomc_ams_sel_t          ams_sel [NPORT];

  // a write through a port whose broadcast bit is set reaches every port, except a write to the broadcast register itself
  wire bcast_src = rgn_port & bcast_r[rgn[0]];

  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      pomc_ams_if ams_bus ();

      wire hit    = (rgn == 2'(p)) | (bcast_src & (idx != `POMC_IDX_BCAST));
      wire wr_p   = wr_acc & rgn_port & hit;
      wire rd_own = rd_acc & (rgn == 2'(p));
      wire wr_ctl = wr_p & (idx == `POMC_IDX_CTRL);
      wire rst_rq = wr_ctl & be16[1] & avs_writedata[`POMC_CTRL_RST_BIT];
      wire wr_mod = wr_p & (idx == `POMC_IDX_MODE);
      wire rd_evt = rd_own & (idx == `POMC_IDX_EVT);
      wire [1:0] evt_set = {swrst_r[p], wr_mod};
      wire [1:0] evt_nxt = (evt_r[p] & ~{2{rd_evt}}) | evt_set;

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ctrl_r[p]     <= `POMC_CTRL_RST;
          adv_r[p]      <= `POMC_ADV_RST;
          bcast_r[p]    <= 1'b0;
          mode_wr_r[p]  <= `POMC_MODE_RST;
          hostan_r[p]   <= 1'b0;
          evt_r[p]      <= 2'h0;
          swrst_r[p]    <= 1'b0;
        end else begin
          // the reset request bit is never stored, so it reads back as zero
          if (wr_ctl) begin
            ctrl_r[p] <= merge16(ctrl_r[p], avs_writedata, be16) & ~16'h8000;
          end
          if (wr_p && idx == `POMC_IDX_ADV) adv_r[p] <= merge16(adv_r[p], avs_writedata, be16);
          if (wr_p && idx == `POMC_IDX_BCAST && be16[0]) begin
            bcast_r[p] <= avs_writedata[`POMC_BCAST_BIT];
          end
          if (wr_mod) mode_wr_r[p] <= merge16(mode_wr_r[p], avs_writedata, be16);
          if (wr_p && idx == `POMC_IDX_HOSTAN && be16[0]) begin
            hostan_r[p] <= avs_writedata[`POMC_HOSTAN_BIT];
          end
          swrst_r[p] <= rst_rq;
          evt_r[p]   <= evt_nxt;
        end
      end

      // a mode write waits in mode_wr_r until software reset copies it over
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          mode_act_r[p] <= `POMC_MODE_RST;
        end else if (swrst_r[p]) begin
          mode_act_r[p] <= mode_wr_r[p];
        end
      end

      // pins from the media side are asynchronous
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cu_sync_r[p] <= 2'h0;
          sd_sync_r[p] <= 2'h0;
        end else begin
          cu_sync_r[p] <= {cu_sync_r[p][0], copper_link_in[p]};
          sd_sync_r[p] <= {sd_sync_r[p][0], serdes_sig_det_in[p]};
        end
      end

      assign ams_bus.en          = mode_act_r[p][`POMC_MODE_AMS_BIT];
      assign ams_bus.pref_serdes = mode_act_r[p][`POMC_MODE_PREF_BIT];
      assign ams_bus.cu_ok       = cu_sync_r[p][1];
      assign ams_bus.serdes_ok   = sd_sync_r[p][1];
      assign ams_sel[p]          = ams_bus.sel;

      pomc_ams_sel u_ams (
        .clk  (clk),
        .rstn (rstn),
        .ams  (ams_bus.sel_side)
      );

      // mode reads show the active mode, not the pending one
      assign port_rd[p] =
        (idx == `POMC_IDX_CTRL)    ? ctrl_r[p] :
        (idx == `POMC_IDX_ADV)     ? adv_r[p] :
        (idx == `POMC_IDX_BCAST)   ? {15'h0000, bcast_r[p]} :
        (idx == `POMC_IDX_MODE)    ? mode_act_r[p] :
        (idx == `POMC_IDX_HOSTAN)  ? {8'h00, hostan_r[p], 7'h00} :
        (idx == `POMC_IDX_AMSSTAT) ? {8'h00, ams_sel[p], 6'h00} :
        (idx == `POMC_IDX_EVT)     ? {14'h0000, evt_r[p]} : 16'h0000;
    end
  endgenerate

  // ---------------- read mux ----------------
  wire [15:0] glb_rd =
    (idx == `POMC_IDX_SERDES)   ? serdes_cfg_r :
    (idx == `POMC_IDX_HOSTMODE) ? host_mode_r : 16'h0000;

  // unmapped addresses read as zero and ignore writes
  assign rdata_nxt = rgn_glb  ? {16'h0000, glb_rd} :
                     rgn_port ? {16'h0000, port_rd[rgn[0]]} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_st_r <= BUS_IDLE;
      rdata_r  <= 32'h0000_0000;
    end else begin
      bus_st_r <= bus_st_nxt;
      if (avs_read && bus_st_r == BUS_IDLE) rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;

  // ---------------- mode outputs ----------------
  logic [NPORT-1:0][1:0]  serdes_media_nxt;
  logic [NPORT-1:0]       serdes_en_nxt;
  logic [NPORT-1:0]       media_aneg_nxt;
  logic [NPORT-1:0]       host_x_nxt;
  logic [NPORT-1:0]       rate_nxt;
  logic [NPORT-1:0]       an37_nxt;
  logic [NPORT-1:0]       ansg_nxt;
  logic [`POMC_SLOTS-1:0] lane_nxt;
  logic [`POMC_SLOTS-1:0] slot_nxt;

  always_comb begin
    lane_nxt = '0;
    slot_nxt = '0;
    for (int i = 0; i < NPORT; i++) begin
      logic [2:0] med;
      med = mode_act_r[i][`POMC_MODE_MED_HI:`POMC_MODE_MED_LO];
      serdes_media_nxt[i] = med[1:0];
      // the low two bits pick the serdes media kind
      serdes_en_nxt[i]    = (med[1:0] != 2'h0) & port_mask[i];
      // 100BASE-FX carries no autonegotiation
      media_aneg_nxt[i]   = ctrl_r[i][`POMC_CTRL_ANEG_BIT]
                            & (med[1:0] != 2'(`POMC_MED_FX100));
      // mode bit 12 picks 1000BASE-X toward the host
      host_x_nxt[i]       = mode_act_r[i][`POMC_MODE_HOSTX_BIT];
      rate_nxt[i]         = ~host_x_nxt[i];
      an37_nxt[i]         = hostan_r[i] & host_x_nxt[i];
      ansg_nxt[i]         = hostan_r[i] & ~host_x_nxt[i];
      if (!hm_qsgmii) lane_nxt[i] = 1'b1;
      if (hm_qsgmii)  slot_nxt[i] = 1'b1;
    end
    if (hm_qsgmii) lane_nxt = `POMC_QSGMII_LANES;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serdes_media_o      <= '0;
      serdes_media_en_o   <= '0;
      media_aneg_en_o     <= '0;
      host_proto_1000x_o  <= '0;
      rate_10_100_allow_o <= '0;
      host_aneg_cl37_o    <= '0;
      host_aneg_sgmii_o   <= '0;
      host_mode_o         <= 2'h0;
      host_lane_en_o      <= '0;
      qsgmii_slot_data_o  <= '0;
    end else begin
      serdes_media_o      <= serdes_media_nxt;
      serdes_media_en_o   <= serdes_en_nxt;
      media_aneg_en_o     <= media_aneg_nxt;
      host_proto_1000x_o  <= host_x_nxt;
      rate_10_100_allow_o <= rate_nxt;
      host_aneg_cl37_o    <= an37_nxt;
      host_aneg_sgmii_o   <= ansg_nxt;
      host_mode_o         <= hmode;
      host_lane_en_o      <= lane_nxt;
      qsgmii_slot_data_o  <= slot_nxt;
    end
  end

  generate
    for (p = 0; p < NPORT; p++) begin : g_out
      assign ams_active_o[p]    = ams_sel[p];
      assign port_sw_reset_o[p] = swrst_r[p];
    end
  endgenerate

endmodule : pomc_mode_cfg

/* pomc_cfg.svh */
// register indices, field positions, reset values and encodings of the mode configuration block
`ifndef POMC_CFG_SVH
`define POMC_CFG_SVH

`define POMC_ADDR_W         10
`define POMC_RGN_HI         9
`define POMC_RGN_LO         8
`define POMC_IDX_HI         7
`define POMC_IDX_LO         2
`define POMC_RGN_GLOBAL     2'h2

`define POMC_IDX_CTRL       6'h00
`define POMC_IDX_ADV        6'h04
`define POMC_IDX_SERDES     6'h12
`define POMC_IDX_HOSTMODE   6'h13
`define POMC_IDX_BCAST      6'h16
`define POMC_IDX_MODE       6'h17
`define POMC_IDX_HOSTAN     6'h30
`define POMC_IDX_AMSSTAT    6'h31
`define POMC_IDX_EVT        6'h32

`define POMC_CTRL_RST_BIT   15
`define POMC_CTRL_ANEG_BIT  12
`define POMC_MODE_HOSTX_BIT 12
`define POMC_MODE_PREF_BIT  11
`define POMC_MODE_AMS_BIT   10
`define POMC_MODE_MED_HI    10
`define POMC_MODE_MED_LO    8
`define POMC_MASK_HI        11
`define POMC_MASK_LO        8
`define POMC_HM_HI          15
`define POMC_HM_LO          14
`define POMC_HOSTAN_BIT     7
`define POMC_AMSSTAT_LO     6
`define POMC_BCAST_BIT      0

`define POMC_MED_PT         3'h1
`define POMC_MED_X1000      3'h2
`define POMC_MED_FX100      3'h3

`define POMC_CTRL_RST       16'h1000
`define POMC_ADV_RST        16'h01E1
`define POMC_MODE_RST       16'h0000
`define POMC_SERDES_RST     16'h0000
`define POMC_HOSTMODE_RST   16'h0000
`define POMC_HOSTAN_RST     16'h0000

`define POMC_QSGMII_LANES   4'h1
`define POMC_SLOTS          4

`endif

/* pomc_pkg.sv */
// types shared by the mode configuration block
package pomc_pkg;

  typedef enum logic [1:0] {
    MED_CU,
    MED_PT,
    MED_X1000,
    MED_FX100
  } pomc_media_t;

  typedef enum logic [1:0] {
    HM_SGMII,
    HM_QSGMII,
    HM_RSV2,
    HM_RSV3
  } pomc_host_mode_t;

  typedef enum logic [1:0] {
    AMS_NONE,
    AMS_CU,
    AMS_SERDES
  } pomc_ams_sel_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } pomc_bus_st_t;

endpackage : pomc_pkg

/* pomc_ams_if.sv */
// carrier between the register block and one automatic media sense selector
interface pomc_ams_if;
  import pomc_pkg::*;

  logic          en;
  logic          pref_serdes;
  logic          cu_ok;
  logic          serdes_ok;
  pomc_ams_sel_t sel;

  modport ctl (output en, output pref_serdes, output cu_ok, output serdes_ok, input sel);
  modport sel_side (input en, input pref_serdes, input cu_ok, input serdes_ok, output sel);
endinterface : pomc_ams_if

/* pomc_ams_sel.sv */
// automatic media sense selector for one port
module pomc_ams_sel
  import pomc_pkg::*;
(
  input wire logic   clk,
  input wire logic   rstn,
  pomc_ams_if.sel_side ams
);

  pomc_ams_sel_t sel_r;
  pomc_ams_sel_t sel_nxt;

  // with both media up the preference decides; with one up, that one wins
  always_comb begin
    sel_nxt = AMS_CU;
    if (!ams.en) begin
      sel_nxt = AMS_NONE;
    end else if (ams.cu_ok && ams.serdes_ok) begin
      sel_nxt = ams.pref_serdes ? AMS_SERDES : AMS_CU;
    end else if (ams.serdes_ok) begin
      sel_nxt = AMS_SERDES;
    end else if (ams.cu_ok) begin
      sel_nxt = AMS_CU;
    end else begin
      sel_nxt = ams.pref_serdes ? AMS_SERDES : AMS_CU;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_r <= AMS_NONE;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  assign ams.sel = sel_r;

endmodule : pomc_ams_sel

/* pomc_mode_cfg_checker.sv */
// port-level assertions for the mode configuration block
`include "pomc_cfg.svh"
module pomc_mode_cfg_checker #(
  parameter int NPORT = 2
) (
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic [`POMC_ADDR_W-1:0]  avs_address,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [31:0]              avs_writedata,
  input wire logic                     avs_waitrequest,
  input wire logic [NPORT-1:0][1:0]    serdes_media_o,
  input wire logic [NPORT-1:0]         serdes_media_en_o,
  input wire logic [NPORT-1:0]         media_aneg_en_o,
  input wire logic [NPORT-1:0]         port_sw_reset_o,
  input wire logic [NPORT-1:0]         host_proto_1000x_o,
  input wire logic [NPORT-1:0]         rate_10_100_allow_o,
  input wire logic [NPORT-1:0]         host_aneg_cl37_o,
  input wire logic [NPORT-1:0]         host_aneg_sgmii_o,
  input wire logic [1:0]               host_mode_o,
  input wire logic [`POMC_SLOTS-1:0]   host_lane_en_o,
  input wire logic [`POMC_SLOTS-1:0]   qsgmii_slot_data_o
);
  logic                   req;
  logic                   rst_wr;
  logic [`POMC_SLOTS-1:0] port_bits;
  assign req = avs_read | avs_write;
  assign rst_wr = avs_write && !avs_waitrequest && avs_address == 10'h000
                  && avs_writedata[`POMC_CTRL_RST_BIT];
  assign port_bits = `POMC_SLOTS'((1 << NPORT) - 1);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_wait_single: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_fx_no_aneg: assert property (serdes_media_o[0] == 2'h3 |-> !media_aneg_en_o[0])
    else $error("autonegotiation on in 100FX media");
  a_media_en_kind: assert property (serdes_media_en_o[0] |-> serdes_media_o[0] != 2'h0)
    else $error("serdes media enabled with copper kind");
  a_rst_after_write: assert property (rst_wr |-> ##[1:3] port_sw_reset_o[0])
    else $error("software reset not applied after control write");
  a_rst_pulse_one: assert property (port_sw_reset_o[0] |=> !port_sw_reset_o[0])
    else $error("software reset pulse longer than one cycle");
  a_rate_inverse: assert property ($past(rstn, 2) |-> rate_10_100_allow_o == ~host_proto_1000x_o)
    else $error("10/100 allowed with 1000X host");
  a_hostan_split: assert property ((host_aneg_cl37_o & host_aneg_sgmii_o) == '0)
    else $error("both host autonegotiation styles on");
  a_qsgmii_lane: assert property (host_mode_o == 2'h1 && $past(host_mode_o) == 2'h1
    && $past(host_mode_o, 2) == 2'h1 |-> host_lane_en_o == 4'h1)
    else $error("qsgmii uses lanes other than 0");
  a_qsgmii_slots: assert property (host_mode_o == 2'h1 && $past(host_mode_o) == 2'h1
    && $past(host_mode_o, 2) == 2'h1 |-> qsgmii_slot_data_o == port_bits)
    else $error("qsgmii data slots wrong");
  a_sgmii_lane: assert property ($past(rstn, 2) && host_mode_o == 2'h0 && $past(host_mode_o) == 2'h0
    && $past(host_mode_o, 2) == 2'h0 |-> host_lane_en_o == port_bits)
    else $error("sgmii lanes wrong");
endmodule : pomc_mode_cfg_checker

bind pomc_mode_cfg pomc_mode_cfg_checker #(.NPORT(NPORT)) u_chk (
  .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .serdes_media_o(serdes_media_o), .serdes_media_en_o(serdes_media_en_o),
  .media_aneg_en_o(media_aneg_en_o), .port_sw_reset_o(port_sw_reset_o),
  .host_proto_1000x_o(host_proto_1000x_o), .rate_10_100_allow_o(rate_10_100_allow_o),
  .host_aneg_cl37_o(host_aneg_cl37_o), .host_aneg_sgmii_o(host_aneg_sgmii_o),
  .host_mode_o(host_mode_o), .host_lane_en_o(host_lane_en_o),
  .qsgmii_slot_data_o(qsgmii_slot_data_o));

/* pomc_mac_model.sv */
// far-side model: media presence pins and the mac's four qsgmii slot windows
module pomc_mac_model #(
  parameter int NPORT = 2
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [NPORT-1:0] cu_cmd,
  input  wire logic [NPORT-1:0] sd_cmd,
  input  wire logic [3:0]       qsgmii_slot_data_o,
  output logic      [NPORT-1:0] copper_link_in,
  output logic      [NPORT-1:0] serdes_sig_det_in,
  output logic      [1:0]       slot_idx,
  output logic                  slot_busy
);
  // windows rotate through all four slots even where only two carry data
  assign slot_busy = qsgmii_slot_data_o[slot_idx];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      copper_link_in    <= '0;
      serdes_sig_det_in <= '0;
      slot_idx          <= 2'h0;
    end else begin
      copper_link_in    <= cu_cmd;
      serdes_sig_det_in <= sd_cmd;
      slot_idx          <= slot_idx + 2'h1;
    end
  end
endmodule : pomc_mac_model

/* tb_pomc_mode_cfg.sv */
// self-checking bench for the mode configuration block
`include "pomc_cfg.svh"
`define TB_CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_pomc_mode_cfg;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NPORT = 2;
  logic                  clk, rstn, avs_read, avs_write, avs_waitrequest, slot_busy;
  logic [9:0]            avs_address;
  logic [31:0]           avs_writedata, avs_readdata, rd;
  logic [3:0]            avs_byteenable, host_lane_en_o, qsgmii_slot_data_o;
  logic [1:0]            host_mode_o, slot_idx;
  logic [NPORT-1:0]      cu_cmd, sd_cmd, copper_link_in, serdes_sig_det_in;
  logic [NPORT-1:0]      serdes_media_en_o, media_aneg_en_o, port_sw_reset_o;
  logic [NPORT-1:0]      host_proto_1000x_o, rate_10_100_allow_o;
  logic [NPORT-1:0]      host_aneg_cl37_o, host_aneg_sgmii_o;
  logic [NPORT-1:0][1:0] serdes_media_o, ams_active_o;
  int                    mismatches, check_count;

  pomc_mode_cfg #(.NPORT(NPORT)) uut (.clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .copper_link_in,
    .serdes_sig_det_in, .serdes_media_o, .serdes_media_en_o, .media_aneg_en_o, .ams_active_o,
    .port_sw_reset_o, .host_proto_1000x_o, .rate_10_100_allow_o, .host_aneg_cl37_o,
    .host_aneg_sgmii_o, .host_mode_o, .host_lane_en_o, .qsgmii_slot_data_o);
  pomc_mac_model #(.NPORT(NPORT)) u_mac (.clk, .rstn, .cu_cmd, .sd_cmd, .qsgmii_slot_data_o,
    .copper_link_in, .serdes_sig_det_in, .slot_idx, .slot_busy);

  function automatic logic [9:0] ad(input logic [1:0] r, input logic [5:0] i);
    return {r, i, 2'b00};
  endfunction : ad

  // request held until the rising edge that samples waitrequest low; data taken there
  task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(negedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      close_out;
    end
    @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    `TB_CHK(rd, e)
  endtask : rdc

  task automatic swr(input logic [1:0] p);
    wr(ad(p, `POMC_IDX_CTRL), 16'h9000);
    repeat (6) @(posedge clk);
  endtask : swr

  task automatic ams(input logic cu, input logic sd, input logic [1:0] e);
    cu_cmd <= {NPORT{cu}};
    sd_cmd <= {NPORT{sd}};
    repeat (8) @(posedge clk);
    bus(1'b0, ad(2'h0, `POMC_IDX_AMSSTAT), 16'h0000);
    `TB_CHK(rd[7:6], e)
    `TB_CHK(ams_active_o[0], e)
  endtask : ams

  task close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100us;
    mismatches++;
    close_out;
  end

  initial begin
    {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'h3;
    cu_cmd = '0;
    sd_cmd = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(ad(2'h0, `POMC_IDX_CTRL), 32'h1000);
    rdc(ad(2'h0, `POMC_IDX_ADV), 32'h01E1);
    rdc(ad(`POMC_RGN_GLOBAL, `POMC_IDX_HOSTMODE), 32'h0);
    rdc(ad(2'h0, 6'h3F), 32'h0);
    `TB_CHK(host_lane_en_o, 4'h3)
    `TB_CHK(rate_10_100_allow_o, 2'h3)
    $display("test reset values done");
    wr(ad(`POMC_RGN_GLOBAL, `POMC_IDX_SERDES), 16'h8FD1);
    wr(ad(2'h0, `POMC_IDX_MODE), 16'h0300);
    rdc(ad(2'h0, `POMC_IDX_MODE), 32'h0);
    rdc(ad(2'h0, `POMC_IDX_EVT), 32'h1);
    rdc(ad(2'h0, `POMC_IDX_EVT), 32'h0);
    swr(2'h0);
    rdc(ad(2'h0, `POMC_IDX_MODE), 32'h0300);
    rdc(ad(2'h0, `POMC_IDX_EVT), 32'h2);
    `TB_CHK(serdes_media_o[0], 2'h3)
    `TB_CHK(media_aneg_en_o[0], 1'b0)
    `TB_CHK(serdes_media_en_o[0], 1'b1)
    wr(ad(`POMC_RGN_GLOBAL, `POMC_IDX_SERDES), 16'h8EC1);
    swr(2'h0);
    `TB_CHK(serdes_media_en_o[0], 1'b0)
    $display("test 100fx and mode reset done");
    for (int k = 1; k < 3; k++) begin
      wr(ad(2'h1, `POMC_IDX_MODE), 16'(k << 8));
      swr(2'h1);
      `TB_CHK(serdes_media_o[1], 2'(k))
      `TB_CHK(media_aneg_en_o[1], 1'b1)
    end
    wr(ad(2'h1, `POMC_IDX_CTRL), 16'h8000);
    repeat (6) @(posedge clk);
    `TB_CHK(media_aneg_en_o[1], 1'b0)
    $display("test media kinds done");
    wr(ad(2'h0, `POMC_IDX_MODE), 16'h0C00);
    swr(2'h0);
    ams(1'b1, 1'b1, 2'h2);
    ams(1'b1, 1'b0, 2'h1);
    ams(1'b0, 1'b1, 2'h2);
    ams(1'b0, 1'b0, 2'h2);
    wr(ad(2'h0, `POMC_IDX_MODE), 16'h0400);
    swr(2'h0);
    ams(1'b1, 1'b1, 2'h1);
    $display("test media sense done");
    wr(ad(2'h0, `POMC_IDX_BCAST), 16'h0001);
    wr(ad(2'h0, `POMC_IDX_HOSTAN), 16'h0080);
    rdc(ad(2'h1, `POMC_IDX_HOSTAN), 32'h80);
    wr(ad(2'h0, `POMC_IDX_BCAST), 16'h0000);
    wr(ad(2'h1, `POMC_IDX_HOSTAN), 16'h0000);
    rdc(ad(2'h0, `POMC_IDX_HOSTAN), 32'h80);
    swr(2'h0);
    `TB_CHK(host_aneg_sgmii_o[0], 1'b1)
    wr(ad(2'h0, `POMC_IDX_MODE), 16'h1000);
    swr(2'h0);
    `TB_CHK(host_proto_1000x_o[0], 1'b1)
    `TB_CHK(rate_10_100_allow_o[0], 1'b0)
    `TB_CHK(host_aneg_cl37_o[0], 1'b1)
    wr(ad(2'h0, `POMC_IDX_ADV), 16'h0001);
    rdc(ad(2'h0, `POMC_IDX_ADV), 32'h1);
    $display("test host side done");
    wr(ad(`POMC_RGN_GLOBAL, `POMC_IDX_HOSTMODE), 16'h4000);
    swr(2'h0);
    `TB_CHK(host_mode_o, 2'h1)
    `TB_CHK(host_lane_en_o, 4'h1)
    `TB_CHK(qsgmii_slot_data_o, 4'h3)
    `TB_CHK(slot_busy, (slot_idx < 2'h2))
    wr(ad(`POMC_RGN_GLOBAL, `POMC_IDX_HOSTMODE), 16'h0000);
    swr(2'h0);
    `TB_CHK(host_lane_en_o, 4'h3)
    `TB_CHK(qsgmii_slot_data_o, 4'h0)
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(ad(2'h0, `POMC_IDX_MODE), 32'h0);
    $display("test qsgmii and second reset done");
    close_out;
  end
endmodule : tb_pomc_mode_cfg
